//--- core/hpc_config_bytes.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "hpc_regs.svh"
// Function
// - the two delay bits pick 50, 100, 200 or 400 ns of over-current filtering.
// - the compound flag set makes the hub report itself as a compound device.
// - in strap configuration any non-removable port forces compound reporting.
// - with remap select clear and no port off, each physical port n is reported as logical n.
// - in standard numbering higher ports shift down past disabled ones.
// - standard enables come from the two port-off masks, both resetting to zero.
// - with remap select set the remap bytes give the logical numbers, reset zero.
// - fixed-port bits 1 to 3 mark ports 1 to 3, the other bits are reserved.
// - the host is told which active ports carry a permanent device.
// - in strap configuration the two fixed-port straps choose the fixed ports.
// - with remap select clear, a port-off bit set in the mask for the current power mode makes that port unavailable to the host.
module hpc_config_bytes
  import hpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic strap_mode,
  input wire logic [1:0] fixed_port_straps,
  input wire logic self_powered,
  input wire logic [3:1] oc_raw,
  output logic [3:1] oc_detect,
  output logic report_compound,
  output logic [3:1] report_fixed,
  output logic [3:1] port_available,
  output logic [1:0] port_count,
  output logic [5:0] logical_numbers
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    hpc_byte_t cfg_two;
    hpc_byte_t cfg_three;
    hpc_byte_t fixed_port_bits;
    hpc_byte_t self_powered_port_off_mask;
    hpc_byte_t bus_powered_port_off_mask;
    hpc_byte_t map12;
    hpc_byte_t map3;
    hpc_byte_t rdata;
  } hpc_state_t;
  hpc_state_t s_q, s_d;
  hpc_map_if m();
  logic [3:1] off;
  logic [3:1] fixed_eff;
  logic [1:0] overcurrent_delay_select;
  logic port_remap_select;

  // fixed-port straps cover ports 1 and 2 only
  function automatic logic [3:1] strap_ports(input logic [1:0] s);
    return {1'b0, s};
  endfunction : strap_ports

  // ----------------------------------------
  // register writes and reads
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (reg_write) begin
      // reserved bits masked off on write
      case (reg_addr)
        `HPC_OFS_CFG_TWO: s_d.cfg_two = reg_wdata & `HPC_CFG_TWO_MASK;
        `HPC_OFS_CFG_THREE: s_d.cfg_three = reg_wdata & `HPC_CFG_THREE_MASK;
        // only port bits 1 to 3 stored
        `HPC_OFS_FIXED: s_d.fixed_port_bits = reg_wdata & `HPC_PORT_MASK;
        `HPC_OFS_OFF_SP: s_d.self_powered_port_off_mask = reg_wdata & `HPC_PORT_MASK;
        `HPC_OFS_OFF_BP: s_d.bus_powered_port_off_mask = reg_wdata & `HPC_PORT_MASK;
        `HPC_OFS_MAP12: s_d.map12 = reg_wdata & 8'h33;
        `HPC_OFS_MAP3: s_d.map3 = reg_wdata & 8'h03;
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `HPC_OFS_CFG_TWO: s_d.rdata = s_q.cfg_two;
        `HPC_OFS_CFG_THREE: s_d.rdata = s_q.cfg_three;
        `HPC_OFS_FIXED: s_d.rdata = s_q.fixed_port_bits;
        `HPC_OFS_OFF_SP: s_d.rdata = s_q.self_powered_port_off_mask;
        `HPC_OFS_OFF_BP: s_d.rdata = s_q.bus_powered_port_off_mask;
        `HPC_OFS_MAP12: s_d.rdata = s_q.map12;
        `HPC_OFS_MAP3: s_d.rdata = s_q.map3;
        `HPC_OFS_STATUS: s_d.rdata = {2'b00, port_count, port_available, 1'b0};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) s_q <= '0;
    else s_q <= s_d;
  end
  assign reg_rdata = s_q.rdata;

  // ----------------------------------------
  // derived hub reporting
  // ----------------------------------------
  assign overcurrent_delay_select = s_q.cfg_two[`HPC_OC_LSB +: 2];
  assign port_remap_select = s_q.cfg_three[`HPC_REMAP_BIT];
  // off bit removes port when remap select is clear, mask chosen by power mode
  assign off = self_powered ? s_q.self_powered_port_off_mask[3:1]
                            : s_q.bus_powered_port_off_mask[3:1];
  // straps choose fixed ports in default configuration
  assign fixed_eff = strap_mode ? strap_ports(fixed_port_straps) : s_q.fixed_port_bits[3:1];
  // fixed reported only for active ports
  assign report_fixed = fixed_eff & port_available;
  // compound flag, strap non-removable forces it
  assign report_compound = s_q.cfg_two[`HPC_COMPOUND_BIT] | (strap_mode & |fixed_eff);

  // standard mode numbering through the mapper
  assign m.remap = port_remap_select;
  assign m.off = off;
  assign m.map12 = s_q.map12;
  assign m.map3 = s_q.map3;
  hpc_port_mapper u_map (
    .m(m)
  );
  assign port_count = m.count;
  assign logical_numbers = {m.logical[3], m.logical[2], m.logical[1]};
  always_comb begin
    for (int p = 1; p <= 3; p++) port_available[p] = (m.logical[p] != 2'd0);
  end

  hpc_oc_filter u_oc (
    .ref_clk(ref_clk),
    .reset(reset),
    .sel(overcurrent_delay_select),
    .raw(oc_raw),
    .filtered(oc_detect)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_compound_flag: assert property (@(posedge ref_clk) disable iff (reset)
    s_q.cfg_two[3] |-> report_compound)
    else $error("compound flag not reported");
  a_strap_compound: assert property (@(posedge ref_clk) disable iff (reset)
    (strap_mode && |fixed_port_straps) |-> report_compound)
    else $error("strap fixed no compound");
  a_identity_map: assert property (@(posedge ref_clk) disable iff (reset)
    (!port_remap_select && off == 3'b000) |-> logical_numbers == 6'b11_10_01)
    else $error("identity numbering wrong");
  a_contiguous_map: assert property (@(posedge ref_clk) disable iff (reset)
    (!port_remap_select && off == 3'b001) |-> logical_numbers == 6'b10_01_00)
    else $error("numbering not contiguous");
  a_off_reset: assert property (@(posedge ref_clk)
    $past(reset) |-> s_q.self_powered_port_off_mask == 8'h00 &&
    s_q.bus_powered_port_off_mask == 8'h00)
    else $error("port-off mask reset wrong");
  a_remap_table: assert property (@(posedge ref_clk) disable iff (reset)
    port_remap_select |-> logical_numbers[1:0] == s_q.map12[1:0])
    else $error("remap ignored");
  a_fixed_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_write && reg_addr == `HPC_OFS_FIXED) |=> s_q.fixed_port_bits[0] == 1'b0 &&
    s_q.fixed_port_bits[7:4] == 4'h0)
    else $error("reserved fixed bit stored");
  a_fixed_active: assert property (@(posedge ref_clk) disable iff (reset)
    |(report_fixed & ~port_available) == 1'b0)
    else $error("fixed on inactive port");
  a_strap_fixed: assert property (@(posedge ref_clk) disable iff (reset)
    (strap_mode && fixed_port_straps[0] && port_available[1]) |-> report_fixed[1])
    else $error("strap fixed ignored");
  a_off_port: assert property (@(posedge ref_clk) disable iff (reset)
    (!port_remap_select && off[2]) |-> !port_available[2])
    else $error("off port available");
  a_reserved_read: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_read && reg_addr == `HPC_OFS_CFG_THREE) |=>
    reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule : hpc_config_bytes

//--- core/hpc_regs.svh
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// register offsets on the plain port
`define HPC_OFS_CFG_TWO 8'he5
`define HPC_OFS_CFG_THREE 8'he6
`define HPC_OFS_FIXED 8'he7
`define HPC_OFS_OFF_SP 8'he8
`define HPC_OFS_OFF_BP 8'he9
`define HPC_OFS_MAP12 8'hfb
`define HPC_OFS_MAP3 8'hfc
`define HPC_OFS_STATUS 8'hf0
// field positions
`define HPC_OC_LSB 4
`define HPC_COMPOUND_BIT 3
`define HPC_REMAP_BIT 3
// writable masks (reserved bits read zero)
`define HPC_CFG_TWO_MASK 8'h38
`define HPC_CFG_THREE_MASK 8'h08
`define HPC_PORT_MASK 8'h0e
// reset values
`define HPC_RST_BYTE 8'h00
// over-current filter delays in ns
`define HPC_OC_NS0 50
`define HPC_OC_NS1 100
`define HPC_OC_NS2 200
`define HPC_OC_NS3 400
`define HPC_CLK_NS 5
`endif

//--- core/hpc_pkg.sv
package hpc_pkg;
  typedef logic [7:0] hpc_byte_t;
  typedef struct packed {
    logic [1:0] phys;
    logic en;
  } hpc_lport_t;
endpackage : hpc_pkg

//--- core/hpc_map_if.sv
`timescale 1ns/1ps
// port-numbering request and answer between top and mapper
interface hpc_map_if;
  logic remap;
  logic [3:1] off;
  logic [7:0] map12;
  logic [7:0] map3;
  logic [1:0] count;
  logic [1:0] logical [3:1];
  modport top (output remap, output off, output map12, output map3,
    input count, input logical);
  modport mapper (input remap, input off, input map12, input map3,
    output count, output logical);
endinterface : hpc_map_if

//--- core/hpc_port_mapper.sv
`timescale 1ns/1ps
module hpc_port_mapper
  import hpc_pkg::*;
(
  hpc_map_if.mapper m
);
  // --------------------------------------------------
  // logical numbering of the three physical ports
  // --------------------------------------------------
  always_comb begin
    logic [1:0] n;
    n = 2'd0;
    for (int p = 1; p <= 3; p++) begin
      m.logical[p] = 2'd0;
      if (m.remap) begin
        if (p == 1) m.logical[p] = m.map12[1:0];
        else if (p == 2) m.logical[p] = m.map12[5:4];
        else m.logical[p] = m.map3[1:0];
        if (m.logical[p] != 2'd0) n = n + 2'd1;
      end else if (!m.off[p]) begin
        n = n + 2'd1;
        m.logical[p] = n;
      end
    end
    m.count = n;
  end
endmodule : hpc_port_mapper

//--- core/hpc_oc_filter.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"
module hpc_oc_filter #(
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] sel,
  input wire logic [3:1] raw,
  output logic [3:1] filtered
);
  localparam logic [CW-1:0] C0 = CW'((`HPC_OC_NS0 + `HPC_CLK_NS - 1) / `HPC_CLK_NS);
  localparam logic [CW-1:0] C1 = CW'((`HPC_OC_NS1 + `HPC_CLK_NS - 1) / `HPC_CLK_NS);
  localparam logic [CW-1:0] C2 = CW'((`HPC_OC_NS2 + `HPC_CLK_NS - 1) / `HPC_CLK_NS);
  localparam logic [CW-1:0] C3 = CW'((`HPC_OC_NS3 + `HPC_CLK_NS - 1) / `HPC_CLK_NS);
  initial begin
    if (CW < 7) $error("hpc_oc_filter: CW too small for 400 ns");
  end
  typedef struct packed {
    logic [2:0][CW-1:0] cnt;
    logic [3:1] out;
  } hpc_oc_state_t;
  hpc_oc_state_t s_q, s_d;
  logic [CW-1:0] limit;
  always_comb begin
    case (sel)
      2'b00: limit = C0;
      2'b01: limit = C1;
      2'b10: limit = C2;
      default: limit = C3;
    endcase
  end
  // count consecutive cycles of raw over-current before asserting
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 3; i++) begin
      if (!raw[i+1]) begin
        s_d.cnt[i] = '0;
        s_d.out[i+1] = 1'b0;
      end else if (s_q.cnt[i] >= limit - CW'(1)) begin
        s_d.out[i+1] = 1'b1;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + CW'(1);
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) s_q <= '0;
    else s_q <= s_d;
  end
  assign filtered = s_q.out;
  // port 1 output rises only if its raw input was high 8 cycles before
  a_oc_delay_min: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(filtered[1]) |-> $past(raw[1], 8))
    else $error("over-current passed too early");
endmodule : hpc_oc_filter

//--- tb/hpc_host_model.sv
`timescale 1ns/1ps
// host side: fetches a hub descriptor snapshot one cycle after a request
module hpc_host_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic get,
  input wire logic report_compound,
  input wire logic [3:1] report_fixed,
  input wire logic [1:0] port_count,
  input wire logic [5:0] logical_numbers,
  output logic desc_valid,
  output logic [11:0] desc
);
  // ---------------------------------------------
  // descriptor capture
  // ---------------------------------------------
  // compound, fixed ports, numbering
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      desc_valid <= 1'b0;
      desc <= 12'h000;
    end else begin
      desc_valid <= get;
      desc <= get ? {report_compound, report_fixed, port_count, logical_numbers} : ~desc;
    end
  end
endmodule : hpc_host_model

//--- tb/hub_port_config_bytes_tb.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"
module hub_port_config_bytes_tb
  import hpc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic strap_mode = 1'b0;
  logic [1:0] fixed_port_straps = 2'h0;
  logic self_powered = 1'b1;
  logic [3:1] oc_raw = 3'h0;
  logic get = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:1] oc_detect, report_fixed, port_available;
  logic report_compound, desc_valid;
  logic [1:0] port_count;
  logic [5:0] logical_numbers;
  logic [11:0] desc;
  int n_fail = 0;
  int n_compared = 0;
  int cnt;
  logic [7:0] ofs [5] = '{`HPC_OFS_CFG_TWO, `HPC_OFS_CFG_THREE, `HPC_OFS_FIXED,
    `HPC_OFS_OFF_SP, `HPC_OFS_OFF_BP};
  logic [7:0] msk [5] = '{8'h38, 8'h08, 8'h0e, 8'h0e, 8'h0e};

  always #2.5 ref_clk = ~ref_clk;

  hpc_config_bytes hpc_config_bytes_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .strap_mode(strap_mode), .fixed_port_straps(fixed_port_straps),
    .self_powered(self_powered), .oc_raw(oc_raw), .oc_detect(oc_detect),
    .report_compound(report_compound), .report_fixed(report_fixed),
    .port_available(port_available), .port_count(port_count),
    .logical_numbers(logical_numbers));
  hpc_host_model hpc_host_model_i (.ref_clk(ref_clk), .reset(reset), .get(get),
    .report_compound(report_compound), .report_fixed(report_fixed), .port_count(port_count),
    .logical_numbers(logical_numbers), .desc_valid(desc_valid), .desc(desc));

  // ---------------------------------------------
  // access and compare tasks
  // ---------------------------------------------
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("rdata %h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd
  task host(input string what, input logic [11:0] exp);
    @(posedge ref_clk);
    get <= 1'b1;
    @(posedge ref_clk);
    get <= 1'b0;
    @(negedge ref_clk);
    chk(what, {4'h1, exp}, {3'h0, desc_valid, desc});
  endtask : host
  task finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00);
    rd(`HPC_OFS_MAP12, 8'h00);
    rd(`HPC_OFS_MAP3, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    wr(8'h42, 8'hff);
    rd(8'h42, 8'h00);
    $display("test reset and access done");
    host("plain numbering", {4'h0, 2'd3, 6'b11_10_01});
    wr(`HPC_OFS_OFF_SP, 8'h04);
    chk("available", 16'h0005, {13'h0, port_available});
    host("self off port2", {4'h0, 2'd2, 6'b10_00_01});
    @(posedge ref_clk);
    self_powered <= 1'b0;
    wr(`HPC_OFS_OFF_BP, 8'h02);
    host("bus off port1", {4'h0, 2'd2, 6'b10_01_00});
    wr(`HPC_OFS_OFF_BP, 8'h00);
    wr(`HPC_OFS_OFF_SP, 8'h00);
    $display("test numbering done");
    wr(`HPC_OFS_FIXED, 8'h02);
    wr(`HPC_OFS_CFG_TWO, 8'h08);
    host("compound reader", {4'h9, 2'd3, 6'b11_10_01});
    wr(`HPC_OFS_CFG_TWO, 8'h00);
    wr(`HPC_OFS_FIXED, 8'h08);
    host("fixed port3", {4'h4, 2'd3, 6'b11_10_01});
    @(posedge ref_clk);
    strap_mode <= 1'b1;
    fixed_port_straps <= 2'h3;
    @(negedge ref_clk);
    host("strap fixed", {4'hb, 2'd3, 6'b11_10_01});
    @(posedge ref_clk);
    strap_mode <= 1'b0;
    wr(`HPC_OFS_FIXED, 8'h00);
    $display("test fixed ports done");
    wr(`HPC_OFS_CFG_THREE, 8'h08);
    wr(`HPC_OFS_MAP12, 8'h23);
    wr(`HPC_OFS_MAP3, 8'h01);
    chk("remap", 16'h001b, {10'h0, logical_numbers});
    wr(`HPC_OFS_CFG_THREE, 8'h00);
    chk("unmapped", 16'h0039, {10'h0, logical_numbers});
    rd(`HPC_OFS_STATUS, 8'h3e);
    $display("test remap done");
    for (int k = 0; k < 4; k++) begin
      wr(`HPC_OFS_CFG_TWO, 8'(k << 4));
      @(posedge ref_clk);
      oc_raw <= 3'h7;
      cnt = 0;
      while (oc_detect !== 3'h7 && cnt < 200) begin
        @(negedge ref_clk);
        cnt++;
      end
      if (cnt < (10 << k) - 1 || cnt > (10 << k) + 2) chk("oc delay", 16'(10 << k), 16'(cnt));
      else chk("oc delay", 16'h0000, 16'h0000);
      @(posedge ref_clk);
      oc_raw <= 3'h0;
      repeat (2) @(negedge ref_clk);
      chk("oc release", 16'h0000, {13'h0, oc_detect});
    end
    $display("test over-current done");
    finish_test();
  end
endmodule : hub_port_config_bytes_tb
